// ==== rtcc_pkg.sv ====
/*
 Constants for the RTC control and status bits block: register offsets,
 field positions, reset values and synchroniser timing.
 Assumes a 32-bit APB register bus and one 125 MHz clock.
*/
//
// Contract
// - Time-of-day alarm sets bit 6 flag
// - Bit 5 gates the ready interrupt
// - Seconds update sets ready flag, bit 4
// - Writing 0 clears ready; 1 ignored
// - Ready clears just before seconds update
// - Busy bit 3 high while write synchronises
// - Bit 2 enables sub-second alarm interrupt
// - Bit 1 enables time-of-day alarm interrupt
// - Bit 0 enable changes only when write-enabled
// - Sub-second alarm sets bit 7 flag
`default_nettype none
package rtcc_pkg;
   localparam logic [11:0] RTCC_CTRL_OFF    = 12'h010;
   localparam logic [11:0] RTCC_WREN_OFF    = 12'h020;
   localparam logic [11:0] RTCC_STAT_OFF    = 12'h024;
   localparam logic [11:0] RTCC_MASK_OFF    = 12'h028;
   localparam int          RTCC_EN_BIT      = 0;
   localparam int          RTCC_TODEN_BIT   = 1;
   localparam int          RTCC_SSEN_BIT    = 2;
   localparam int          RTCC_BUSY_BIT    = 3;
   localparam int          RTCC_RDY_BIT     = 4;
   localparam int          RTCC_RDYEN_BIT   = 5;
   localparam int          RTCC_TODFL_BIT   = 6;
   localparam int          RTCC_SSFL_BIT    = 7;
   localparam int          RTCC_EVT_N       = 3;
   localparam logic [2:0]  RTCC_EVT_RST     = 3'h0;
   localparam logic [2:0]  RTCC_MASK_RST    = 3'h7;
   localparam int          RTCC_SYNC_NS     = 48;
   localparam int          RTCC_CLK_NS      = 8;
   localparam int          RTCC_SYNC_CYC    =
      (RTCC_SYNC_NS + RTCC_CLK_NS - 1) / RTCC_CLK_NS;
   localparam logic [7:0]  RTCC_SYNC_CNT    = 8'(RTCC_SYNC_CYC);
endpackage
`default_nettype wire

// ==== rtcc_sync_timer.sv ====
/*
 Busy timer: models the crossing of a control write into the slow RTC
 domain by a fixed settle count.
 Assumes start is a one-cycle pulse from the register slave.
*/
`timescale 1ns/10ps
`default_nettype none
module rtcc_sync_timer
   import rtcc_pkg::*;
#(
   parameter logic [7:0] CYCLES = rtcc_pkg::RTCC_SYNC_CNT
)(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   logic [7:0] count_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_r <= 8'h00;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else if (start) begin
         count_r <= CYCLES;
         busy    <= 1'b1;
         done    <= 1'b0;
      end else if (count_r != 8'h00) begin
         count_r <= count_r - 8'h01;
         busy    <= (count_r != 8'h01);
         done    <= (count_r == 8'h01);
      end else begin
         done <= 1'b0;
      end
   end

   busyBound_a: assert property (@(posedge clk) disable iff (reset)
      start |=> busy [*2]) else $error("busy did not hold after start");
   // busy clears after the default settle count
   busyClear_a: assert property (@(posedge clk) disable iff (reset)
      start ##1 !start [*6] |=> !busy) else $error("busy stuck");
endmodule
`default_nettype wire

// ==== rtcc_event_flags.sv ====
/*
 Sticky event flags with write-one-to-clear and a mask onto one level
 interrupt. Set wins over a clear in the same cycle.
 Assumes set pulses and clear strobes are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module rtcc_event_flags
   import rtcc_pkg::*;
#(
   parameter int N = rtcc_pkg::RTCC_EVT_N
)(
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [N-1:0] setEvt,
   input  wire logic [N-1:0] clrEvt,
   input  wire logic [N-1:0] maskWr,
   input  wire logic         maskWe,
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gFlag
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               status[g] <= 1'b0;
            end else if (setEvt[g]) begin
               status[g] <= 1'b1;
            end else if (clrEvt[g]) begin
               status[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mask <= RTCC_MASK_RST[N-1:0];
         irq  <= 1'b0;
      end else begin
         if (maskWe) begin
            mask <= maskWr;
         end
         irq <= |(status & mask);
      end
   end

   setWins_a: assert property (@(posedge clk) disable iff (reset)
      setEvt[0] && clrEvt[0] |=> status[0]) else $error("set lost");
endmodule
`default_nettype wire

// ==== rtcc_ctrl.sv ====
/*
 RTC control register, lower bits: alarm flags, ready flag and enable,
 busy, alarm enables and clock enable, plus event status and mask.
 Assumes an APB master, alarm match pulses and a seconds update strobe
 with a pre-update warning pulse from the timekeeping counters.
*/
`timescale 1ns/10ps
`default_nettype none
module rtcc_ctrl
   import rtcc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        secPreUpdate,
   input  wire logic        secUpdated,
   input  wire logic        dayAlarmHit,
   input  wire logic        subAlarmHit,
   output logic             rtcEnable,
   output logic             dayAlarmEnable,
   output logic             subAlarmEnable,
   output logic             rtcIrq,
   output logic             evtIrq
);
   logic       dayAlarmFlag_r;
   logic       subsecondAlarmFlag_r;
   logic       ready_r;
   logic       readyIntEn_r;
   logic       writeEnable_r;
   logic       busy;
   logic       syncDone;
   logic       syncStart;
   logic [2:0] evtStatus;
   logic [2:0] evtMask;
   logic [2:0] evtClr;
   logic       wrCycle;
   logic       ctrlWr;
   logic       flagIrqNxt;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction

   assign wrCycle = psel && penable && pwrite;
   assign ctrlWr  = wrCycle && hit(paddr, RTCC_CTRL_OFF);
   // Any enable-bit write runs through the slow-domain settle
   assign syncStart = ctrlWr;

   rtcc_sync_timer #(
      .CYCLES (RTCC_SYNC_CNT)
   ) uSync (
      .clk   (clk),
      .reset (reset),
      .start (syncStart),
      .busy  (busy),
      .done  (syncDone)
   );

   // Single-cycle access phase: pready high in the cycle after the setup phase only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable &&
                    !(hit(paddr, RTCC_CTRL_OFF) || hit(paddr, RTCC_WREN_OFF)
                      || hit(paddr, RTCC_STAT_OFF)
                      || hit(paddr, RTCC_MASK_OFF));
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         subAlarmEnable <= 1'b0;
      end else if (ctrlWr && pready) begin
         subAlarmEnable <= pwdata[RTCC_SSEN_BIT];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dayAlarmEnable <= 1'b0;
      end else if (ctrlWr && pready) begin
         dayAlarmEnable <= pwdata[RTCC_TODEN_BIT];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         readyIntEn_r <= 1'b0;
      end else if (ctrlWr && pready) begin
         readyIntEn_r <= pwdata[RTCC_RDYEN_BIT];
      end
   end

   // Write-enable latch; gates the clock enable bit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         writeEnable_r <= 1'b0;
      end else if (wrCycle && pready && hit(paddr, RTCC_WREN_OFF)) begin
         writeEnable_r <= pwdata[0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rtcEnable <= 1'b0;
      end else if (ctrlWr && pready && writeEnable_r) begin
         rtcEnable <= pwdata[RTCC_EN_BIT];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ready_r <= 1'b0;
      end else if (secUpdated) begin
         ready_r <= 1'b1;
      end else if (secPreUpdate) begin
         ready_r <= 1'b0;
      end else if (ctrlWr && pready && !pwdata[RTCC_RDY_BIT]) begin
         ready_r <= 1'b0;
      end
   end

   // day flag: cleared by writing 0, a hit wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dayAlarmFlag_r <= 1'b0;
      end else if (dayAlarmHit) begin
         dayAlarmFlag_r <= 1'b1;
      end else if (ctrlWr && pready && !pwdata[RTCC_TODFL_BIT]) begin
         dayAlarmFlag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         subsecondAlarmFlag_r <= 1'b0;
      end else if (subAlarmHit) begin
         subsecondAlarmFlag_r <= 1'b1;
      end else if (ctrlWr && pready && !pwdata[RTCC_SSFL_BIT]) begin
         subsecondAlarmFlag_r <= 1'b0;
      end
   end

   assign flagIrqNxt = (dayAlarmFlag_r && dayAlarmEnable) ||
                       (subsecondAlarmFlag_r && subAlarmEnable) ||
                       (ready_r && readyIntEn_r);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rtcIrq <= 1'b0;
      end else begin
         rtcIrq <= flagIrqNxt;
      end
   end

   assign evtClr = (wrCycle && pready && hit(paddr, RTCC_STAT_OFF)) ?
                   pwdata[2:0] : 3'h0;

   // Events: seconds update, alarm, synchronisation done
   rtcc_event_flags #(
      .N (RTCC_EVT_N)
   ) uEvt (
      .clk    (clk),
      .reset  (reset),
      .setEvt ({syncDone, dayAlarmHit | subAlarmHit, secUpdated}),
      .clrEvt (evtClr),
      .maskWr (pwdata[2:0]),
      .maskWe (wrCycle && pready && hit(paddr, RTCC_MASK_OFF)),
      .status (evtStatus),
      .mask   (evtMask),
      .irq    (evtIrq)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            RTCC_CTRL_OFF: prdata <= {24'h00_0000, subsecondAlarmFlag_r,
               dayAlarmFlag_r, readyIntEn_r, ready_r, busy,
               subAlarmEnable, dayAlarmEnable, rtcEnable};
            RTCC_WREN_OFF: prdata <= {31'h0, writeEnable_r};
            RTCC_STAT_OFF: prdata <= {29'h0, evtStatus};
            RTCC_MASK_OFF: prdata <= {29'h0, evtMask};
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   readySet_a: assert property (@(posedge clk) disable iff (reset)
      secUpdated |=> ready_r) else $error("ready not set");
   readyDrop_a: assert property (@(posedge clk) disable iff (reset)
      secPreUpdate && !secUpdated |=> !ready_r) else $error("ready held");
   readyKeep_a: assert property (@(posedge clk) disable iff (reset)
      ready_r && ctrlWr && pready && pwdata[RTCC_RDY_BIT] && !secPreUpdate
      |=> ready_r) else $error("ready lost on write 1");
   dayFlag_a: assert property (@(posedge clk) disable iff (reset)
      dayAlarmHit |=> dayAlarmFlag_r) else $error("day flag");
   subFlag_a: assert property (@(posedge clk) disable iff (reset)
      subAlarmHit |=> subsecondAlarmFlag_r) else $error("sub flag");
   enLock_a: assert property (@(posedge clk) disable iff (reset)
      !writeEnable_r |=> $stable(rtcEnable)) else $error("enable moved");
   irqFlag_a: assert property (@(posedge clk) disable iff (reset)
      flagIrqNxt |=> rtcIrq) else $error("irq missing");
   busyWr_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready |=> ##1 busy) else $error("no busy");
   rdyGate_a: assert property (@(posedge clk) disable iff (reset)
      !flagIrqNxt |=> !rtcIrq) else $error("spurious irq");
   ssEn_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready |=> subAlarmEnable == $past(pwdata[RTCC_SSEN_BIT]))
      else $error("ss enable");
   rdyIrq_a: assert property (@(posedge clk) disable iff (reset)
      ready_r && readyIntEn_r |=> rtcIrq) else $error("ready irq missing");
   rdyEn_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready |=> readyIntEn_r == $past(pwdata[RTCC_RDYEN_BIT]))
      else $error("ready enable");
   todEn_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready |=> dayAlarmEnable == $past(pwdata[RTCC_TODEN_BIT]))
      else $error("day enable");
   rdyClr_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready && !pwdata[RTCC_RDY_BIT] && !secUpdated |=> !ready_r)
      else $error("ready not cleared");
   rdyHold_a: assert property (@(posedge clk) disable iff (reset)
      !ready_r && !secUpdated |=> !ready_r) else $error("ready set early");
   dayClr_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready && !pwdata[RTCC_TODFL_BIT] && !dayAlarmHit
      |=> !dayAlarmFlag_r) else $error("day flag not cleared");
   // day flag rises only on a hit
   dayHold_a: assert property (@(posedge clk) disable iff (reset)
      !dayAlarmFlag_r && !dayAlarmHit |=> !dayAlarmFlag_r)
      else $error("day flag set early");
   subClr_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready && !pwdata[RTCC_SSFL_BIT] && !subAlarmHit
      |=> !subsecondAlarmFlag_r) else $error("sub flag not cleared");
   // sub flag rises only on a hit
   subHold_a: assert property (@(posedge clk) disable iff (reset)
      !subsecondAlarmFlag_r && !subAlarmHit |=> !subsecondAlarmFlag_r)
      else $error("sub flag set early");
   enWr_a: assert property (@(posedge clk) disable iff (reset)
      ctrlWr && pready && writeEnable_r
      |=> rtcEnable == $past(pwdata[RTCC_EN_BIT]))
      else $error("enable write");
   busyRd_a: assert property (@(posedge clk) disable iff (reset)
      psel && !penable && !pwrite && paddr == RTCC_CTRL_OFF
      |=> prdata[RTCC_BUSY_BIT] == $past(busy)) else $error("busy readback");

   // One-cycle answer, no wait states
   apbRdy_a: assert property (@(posedge clk) disable iff (reset)
      psel && !penable |=> pready) else $error("no ready");
   apbPulse_a: assert property (@(posedge clk) disable iff (reset)
      pready |=> !pready) else $error("ready held");
   apbErr_a: assert property (@(posedge clk) disable iff (reset)
      pslverr |-> pready) else $error("error without ready");

   // Event interrupt follows unmasked status one clock late
   evtOn_a: assert property (@(posedge clk) disable iff (reset)
      |(evtStatus & evtMask) |=> evtIrq) else $error("event irq missing");
   evtOff_a: assert property (@(posedge clk) disable iff (reset)
      !(|(evtStatus & evtMask)) |=> !evtIrq) else $error("event irq stuck");
   syncEvt_a: assert property (@(posedge clk) disable iff (reset)
      syncDone |=> evtStatus[2]) else $error("sync event lost");
   secEvt_a: assert property (@(posedge clk) disable iff (reset)
      secUpdated |=> evtStatus[0]) else $error("seconds event lost");
   almEvt_a: assert property (@(posedge clk) disable iff (reset)
      dayAlarmHit || subAlarmHit |=> evtStatus[1])
      else $error("alarm event lost");

   cEnable_c: cover property (@(posedge clk) ctrlWr && pready && writeEnable_r);
   cReady_c: cover property (@(posedge clk) secPreUpdate ##[1:8] secUpdated);
   cIrq_c: cover property (@(posedge clk) dayAlarmHit ##2 rtcIrq);
   cBusy_c: cover property (@(posedge clk) syncStart ##7 !busy);
   cSubIrq_c: cover property (@(posedge clk) subAlarmHit ##2 rtcIrq);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 Self-checking bench for the RTC control and status bits block.
 Assumes rtcc_pkg and rtcc_ctrl are compiled first; one 125 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import rtcc_pkg::*;
   logic        clk, reset, psel, penable, pwrite, pErr, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        secPreUpdate, secUpdated, dayAlarmHit, subAlarmHit;
   logic        rtcEnable, dayAlarmEnable, subAlarmEnable, rtcIrq, evtIrq;
   int          nFail = 0;
   int          checksDone = 0;

   rtcc_ctrl rtcc_ctrl_i (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .secPreUpdate(secPreUpdate), .secUpdated(secUpdated),
      .dayAlarmHit(dayAlarmHit), .subAlarmHit(subAlarmHit),
      .rtcEnable(rtcEnable), .dayAlarmEnable(dayAlarmEnable),
      .subAlarmEnable(subAlarmEnable), .rtcIrq(rtcIrq), .evtIrq(evtIrq));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic testDone;
      $display("Checks %0d, mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   // Idle edge at the end so the next setup never lands in the same step
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) chkBit(1'b0, 1'b1);
      rd = prdata;
      pErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chkWord(rd, exp);
   endtask

   // Busy must show right after a write and clear within a bounded poll
   task automatic ctrlWr(input logic [31:0] d);
      int k;
      apb(1'b0, RTCC_CTRL_OFF, 32'h0);
      chkBit(rd[RTCC_BUSY_BIT], 1'b0);
      apb(1'b1, RTCC_CTRL_OFF, d);
      apb(1'b0, RTCC_CTRL_OFF, 32'h0);
      chkBit(rd[RTCC_BUSY_BIT], 1'b1);
      k = 0;
      while (rd[RTCC_BUSY_BIT] !== 1'b0 && k < 20) begin
         apb(1'b0, RTCC_CTRL_OFF, 32'h0);
         k++;
      end
      chkBit(rd[RTCC_BUSY_BIT], 1'b0);
   endtask

   task automatic pulse(input logic [3:0] v);
      {subAlarmHit, dayAlarmHit, secUpdated, secPreUpdate} <= v;
      @(posedge clk);
      {subAlarmHit, dayAlarmHit, secUpdated, secPreUpdate} <= 4'h0;
      repeat (2) @(posedge clk);
   endtask

   initial begin
      #100000;
      nFail++;
      $display("[ERR] %0t timeout", $time);
      testDone();
   end

   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {subAlarmHit, dayAlarmHit, secUpdated, secPreUpdate} = 4'h0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rdChk(RTCC_CTRL_OFF, 32'h0);
      chkBit(pErr, 1'b0);
      rdChk(RTCC_MASK_OFF, 32'h7);
      chkBit(evtIrq, 1'b0);
      $display("Test reset done");
      // Enable bit refused without write-enable
      ctrlWr(32'h07);
      rdChk(RTCC_CTRL_OFF, 32'h06);
      chkBit(rtcEnable, 1'b0);
      chkBit(dayAlarmEnable, 1'b1);
      chkBit(subAlarmEnable, 1'b1);
      apb(1'b1, RTCC_WREN_OFF, 32'h1);
      ctrlWr(32'h07);
      chkBit(rtcEnable, 1'b1);
      apb(1'b1, RTCC_WREN_OFF, 32'h0);
      ctrlWr(32'h06);
      chkBit(rtcEnable, 1'b1);
      $display("Test enables done");
      pulse(4'b0010);
      rdChk(RTCC_CTRL_OFF, 32'h17);
      chkBit(rtcIrq, 1'b0);
      ctrlWr(32'h37);
      rdChk(RTCC_CTRL_OFF, 32'h37);
      chkBit(rtcIrq, 1'b1);
      pulse(4'b0001);
      rdChk(RTCC_CTRL_OFF, 32'h27);
      chkBit(rtcIrq, 1'b0);
      pulse(4'b0010);
      ctrlWr(32'h27);
      rdChk(RTCC_CTRL_OFF, 32'h27);
      $display("Test ready done");
      pulse(4'b0100);
      rdChk(RTCC_CTRL_OFF, 32'h67);
      chkBit(rtcIrq, 1'b1);
      ctrlWr(32'h65);
      rdChk(RTCC_CTRL_OFF, 32'h65);
      chkBit(rtcIrq, 1'b0);
      ctrlWr(32'h25);
      rdChk(RTCC_CTRL_OFF, 32'h25);
      pulse(4'b1000);
      rdChk(RTCC_CTRL_OFF, 32'hA5);
      chkBit(rtcIrq, 1'b1);
      ctrlWr(32'h21);
      rdChk(RTCC_CTRL_OFF, 32'h21);
      chkBit(rtcIrq, 1'b0);
      $display("Test alarms done");
      rdChk(RTCC_STAT_OFF, 32'h7);
      chkBit(evtIrq, 1'b1);
      apb(1'b1, RTCC_STAT_OFF, 32'h7);
      rdChk(RTCC_STAT_OFF, 32'h0);
      chkBit(evtIrq, 1'b0);
      apb(1'b1, RTCC_MASK_OFF, 32'h0);
      pulse(4'b0010);
      rdChk(RTCC_STAT_OFF, 32'h1);
      chkBit(evtIrq, 1'b0);
      apb(1'b1, RTCC_MASK_OFF, 32'h1);
      // Interrupt follows the new mask one clock late
      @(posedge clk);
      chkBit(evtIrq, 1'b1);
      rdChk(12'h030, 32'h0);
      chkBit(pErr, 1'b1);
      $display("Test events done");
      chkBit(rtcIrq, 1'b1);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rdChk(RTCC_CTRL_OFF, 32'h0);
      chkBit(rtcEnable, 1'b0);
      chkBit(rtcIrq, 1'b0);
      rdChk(RTCC_MASK_OFF, 32'h7);
      chkBit(evtIrq, 1'b0);
      $display("Test reset again done");
      testDone();
   end
endmodule
`default_nettype wire
